// ---- dual_hbridge_chopper_control.sv ----
// dual h-bridge control: decode, chopping, protection and sleep
`default_nettype none
// Operation
// - decode input pair into coast/reverse/forward/brake
// - two identical independent bridge controllers
// - sense trip cuts drive until next period
// - ignore sense for blanking after drive enable
// - blanking is the minimum on-time
// - trip flag means sense reached reference
// - after trip both low sides on
// - sleep turns bridges off, resets logic
// - inputs ignored while asleep
// - outputs wait wake interval after sleep release
// - persistent current limit shuts bridge, fault low
// - retry period re-enables bridge and fault
// - overcurrent shuts only the affected bridge
// - overcurrent per switch, independent of sense
// - thermal flag disables bridges, reports fault
// - undervoltage resets the control state until recovery
// - fault output low during undervoltage
// - active when awake and fault free
// - chopping period generated internally, 50 kHz
// - internal dead time between half-bridge switches
module dual_hbridge_chopper_control
   import hbridge_pkg::*;
#(
   parameter int unsigned wake_cycles_p  = wake_cycles,
   parameter int unsigned retry_cycles_p = ocp_retry_cycles
) (
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic                  bridge_a_input_one,
   input  wire logic                  bridge_a_input_two,
   input  wire logic                  bridge_b_input_one,
   input  wire logic                  bridge_b_input_two,
   input  wire logic                  sleep_request_n,
   input  wire logic                  bridge_a_current_sense_trip,
   input  wire logic                  bridge_b_current_sense_trip,
   input  wire overcurrent_flags_type bridge_a_overcurrent_guard,
   input  wire overcurrent_flags_type bridge_b_overcurrent_guard,
   input  wire logic                  thermal_cutoff,
   input  wire logic                  supply_low_lockout,
   output half_gate_type              bridge_a_output_one,
   output half_gate_type              bridge_a_output_two,
   output half_gate_type              bridge_b_output_one,
   output half_gate_type              bridge_b_output_two,
   output logic                       fault_indicator_n_out,
   output logic                       fault_indicator_n_oe
);
   // end values that follow the shortenable parameters
   localparam logic [wake_cnt_w-1:0]  wake_last  = wake_cnt_w'(wake_cycles_p - 1);
   localparam logic [retry_cnt_w-1:0] retry_last = retry_cnt_w'(retry_cycles_p - 1);

   pin_sample_type        raw;
   pin_sample_type        smp;
   ctrl_state_type        st;
   ctrl_state_type        next_st;
   bridge_gate_type [1:0] want;
   logic [1:0]            drive;
   half_gate_type [1:0]   gate_one;
   half_gate_type [1:0]   gate_two;

   // gather pins, index 0 is bridge a
   assign raw.bridge_in[0] = {bridge_a_input_one, bridge_a_input_two};
   assign raw.bridge_in[1] = {bridge_b_input_one, bridge_b_input_two};
   assign raw.trip         = {bridge_b_current_sense_trip, bridge_a_current_sense_trip};
   assign raw.oc[0]        = bridge_a_overcurrent_guard;
   assign raw.oc[1]        = bridge_b_overcurrent_guard;
   assign raw.sleep_n      = sleep_request_n;
   assign raw.thermal      = thermal_cutoff;
   assign raw.supply_low   = supply_low_lockout;

   // comparator flags are asynchronous to sys_clk, so all pins pass two stages
   input_sync #(
      .width ($bits(pin_sample_type))
   ) u_pin_sync (
      .async_in (raw),
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .sync_out (smp)
   );

   // wake timer, period timer, per-bridge chopping and protection
   always_comb begin
      next_st              = st;
      next_st.period_start = 1'b0;
      want                 = {gates_off, gates_off};
      drive                = 2'b00;

      // clocks stop while asleep, so the period timer only runs awake
      if (!st.awake) begin
         next_st.wake_cnt = st.wake_cnt + 1'b1;
         if (st.wake_cnt == wake_last) begin
            next_st.awake = 1'b1;
         end
      end else if (st.period_cnt == period_last) begin
         next_st.period_cnt   = '0;
         next_st.period_start = 1'b1;
      end else begin
         next_st.period_cnt = st.period_cnt + 1'b1;
      end

      for (int b = 0; b < 2; b++) begin
         // pwm on one input passes straight through the decode
         unique case (smp.bridge_in[b])
            2'h0: want[b] = gates_off;
            2'h1: want[b] = gates_reverse;
            2'h2: want[b] = gates_forward;
            2'h3: want[b] = gates_brake;
         endcase
         drive[b] = smp.bridge_in[b].one ^ smp.bridge_in[b].two;

         // blanking restarts whenever drive is re-enabled
         if (drive[b] && (!st.driving[b] || st.period_start)) begin
            next_st.blank_cnt[b] = blank_load;
         end else if (st.blank_cnt[b] != '0) begin
            next_st.blank_cnt[b] = st.blank_cnt[b] - 1'b1;
         end
         next_st.driving[b] = drive[b];

         // trip only counts once blanking is over; the count is stale
         // in the cycle drive starts, so that cycle never chops
         if (!drive[b] || st.period_start) begin
            next_st.chopped[b] = 1'b0;
         end else if (st.driving[b] && st.blank_cnt[b] == '0 && smp.trip[b]) begin
            next_st.chopped[b] = 1'b1;
         end
         if (st.chopped[b]) begin
            want[b] = gates_brake;
         end

         // overcurrent: deglitch, shut down, retry
         if (st.shutdown[b]) begin
            next_st.deglitch_cnt[b] = '0;
            if (st.retry_cnt[b] == '0) begin
               next_st.shutdown[b] = 1'b0;
            end else begin
               next_st.retry_cnt[b] = st.retry_cnt[b] - 1'b1;
            end
         end else if (|smp.oc[b]) begin
            if (st.deglitch_cnt[b] == deglitch_last) begin
               next_st.shutdown[b]     = 1'b1;
               next_st.retry_cnt[b]    = retry_last;
               next_st.deglitch_cnt[b] = '0;
            end else begin
               next_st.deglitch_cnt[b] = st.deglitch_cnt[b] + 1'b1;
            end
         end else begin
            next_st.deglitch_cnt[b] = '0;
         end

         // any fault or sleep turns every switch of the bridge off
         if (!st.awake || st.shutdown[b] || smp.thermal) begin
            want[b] = gates_off;
         end
      end

      next_st.fault = (|st.shutdown) | smp.thermal | smp.supply_low;

      // sleep or low supply holds the control state in reset; undervoltage still reports
      if (!smp.sleep_n || smp.supply_low) begin
         next_st       = ctrl_reset;
         next_st.fault = smp.supply_low;
      end
      next_st.fault_n = !next_st.fault;
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st <= ctrl_reset;
      end else begin
         st <= next_st;
      end
   end

   // four half-bridges, each with its own dead-time guard
   for (genvar b = 0; b < 2; b++) begin : g_bridge
      half_gate_guard u_guard_one (
         .sys_clk (sys_clk),
         .resetn  (resetn),
         .enable  (st.awake),
         .want    (want[b].one),
         .gate    (gate_one[b])
      );
      half_gate_guard u_guard_two (
         .sys_clk (sys_clk),
         .resetn  (resetn),
         .enable  (st.awake),
         .want    (want[b].two),
         .gate    (gate_two[b])
      );
   end

   // outputs come from the guard and state flops
   assign bridge_a_output_one   = gate_one[0];
   assign bridge_a_output_two   = gate_two[0];
   assign bridge_b_output_one   = gate_one[1];
   assign bridge_b_output_two   = gate_two[1];
   assign fault_indicator_n_out = st.fault_n;
   assign fault_indicator_n_oe  = st.fault;  // open drain, drives low only

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence s_wake_done;
      !st.awake ##1 st.awake;
   endsequence

   a_sleep_outputs_off: assert property (!st.awake |=> gate_one == '0 && gate_two == '0)
      else $error("bridge driven while asleep");

   a_wake_interval: assert property (s_wake_done |-> $past(st.wake_cnt) == wake_last)
      else $error("wake interval not honoured");

   a_period_rate: assert property (st.period_start |->
      $past(st.period_cnt) == period_last && $past(st.awake))
      else $error("chopping period wrong length");

   a_fault_report: assert property ((smp.supply_low || (smp.sleep_n && (|st.shutdown || smp.thermal)))
      |=> fault_indicator_n_oe && !fault_indicator_n_out)
      else $error("fault not reported");

   // protection and sleep leave the bridges and state quiet; the fault pin clears once no cause remains
   a_thermal_off: assert property (smp.thermal |=> gate_one == '0 && gate_two == '0)
      else $error("bridge driven during thermal cutoff");

   a_lockout_reset: assert property (smp.supply_low |=> !st.awake && st.shutdown == '0)
      else $error("logic not reset by supply lockout");

   a_sleep_ignore: assert property (!smp.sleep_n |=> !st.awake && st.chopped == '0 && st.wake_cnt == '0)
      else $error("state moved while asleep");

   a_fault_clear: assert property (smp.sleep_n && !smp.supply_low && !smp.thermal && st.shutdown == '0
      |=> !fault_indicator_n_oe && fault_indicator_n_out)
      else $error("fault reported without a cause");

   for (genvar b = 0; b < 2; b++) begin : g_check
      sequence s_drive_start;
         !st.driving[b] ##1 st.driving[b];
      endsequence

      sequence s_ocp_entry;
         !st.shutdown[b] ##1 st.shutdown[b];
      endsequence

      sequence s_coast_held;
         (smp.bridge_in[b] == 2'h0) [*2];
      endsequence

      a_decode_forward: assert property (gate_one[b].high |-> $past(smp.bridge_in[b]) == 2'h2)
         else $error("first output high without forward command");

      a_decode_reverse: assert property (gate_two[b].high |-> $past(smp.bridge_in[b]) == 2'h1)
         else $error("second output high without reverse command");

      a_blank_ignore: assert property ($rose(st.chopped[b]) |-> $past(st.blank_cnt[b]) == '0
         && $past(st.driving[b]) && !$past(st.period_start))
         else $error("trip acted on inside blanking");

      a_min_on_time: assert property (s_drive_start |-> !st.chopped[b] [*8])
         else $error("drive cut before blanking end");

      a_chop_hold: assert property (st.chopped[b] && drive[b] && !st.period_start && smp.sleep_n
         && !smp.supply_low |=> st.chopped[b])
         else $error("chop released before next period");

      a_slow_decay: assert property (st.chopped[b] |=> !gate_one[b].high && !gate_two[b].high)
         else $error("high side on while chopped");

      a_ocp_deglitch: assert property (s_ocp_entry |->
         $past(st.deglitch_cnt[b]) == deglitch_last && $past(|smp.oc[b]))
         else $error("shutdown without deglitched overcurrent");

      a_ocp_bridge_off: assert property (st.shutdown[b] |=> gate_one[b] == '0 && gate_two[b] == '0)
         else $error("bridge driven during overcurrent shutdown");

      a_ocp_retry_end: assert property ($fell(st.shutdown[b]) && $past(smp.sleep_n) &&
         !$past(smp.supply_low) |-> $past(st.retry_cnt[b]) == '0)
         else $error("shutdown released before retry period");

      // per-bridge decode, chopping and retry steps
      a_coast_decode: assert property (s_coast_held |=> gate_one[b] == '0 && gate_two[b] == '0)
         else $error("outputs driven in coast");

      a_blank_load: assert property (s_drive_start |-> st.blank_cnt[b] == blank_load)
         else $error("blanking not restarted with drive");

      a_chop_release: assert property (st.period_start |=> !st.chopped[b])
         else $error("chop held across period start");

      a_trip_sets: assert property (st.driving[b] && drive[b] && st.blank_cnt[b] == '0 && smp.trip[b]
         && !st.period_start && smp.sleep_n && !smp.supply_low |=> st.chopped[b])
         else $error("trip past blanking not acted on");

      a_retry_load: assert property (s_ocp_entry |-> st.retry_cnt[b] == retry_last)
         else $error("retry period not loaded");

      a_deglitch_reset: assert property (!(|smp.oc[b]) |=> st.deglitch_cnt[b] == '0)
         else $error("deglitch count kept without overcurrent");
   end
endmodule : dual_hbridge_chopper_control
`default_nettype wire

// ---- hbridge_pkg.sv ----
// constants and carrier types shared by the dual bridge controller
`default_nettype none
package hbridge_pkg;
   // clock period
   localparam int unsigned clk_period_ns       = 10;
   // internal chopping rate in kHz
   localparam int unsigned chop_freq_khz       = 50;
   localparam int unsigned chop_period_cycles  = 1000000 / (chop_freq_khz * clk_period_ns);
   // least times, rounded up to whole cycles
   localparam int unsigned blank_time_ns       = 3750;
   localparam int unsigned blank_cycles        = (blank_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int unsigned dead_time_ns        = 450;
   localparam int unsigned dead_cycles         = (dead_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int unsigned ocp_deglitch_ns     = 4000;
   localparam int unsigned ocp_deglitch_cycles = (ocp_deglitch_ns + clk_period_ns - 1) / clk_period_ns;
   // longest times, rounded down
   localparam int unsigned wake_time_us        = 1000;
   localparam int unsigned wake_cycles         = wake_time_us * 1000 / clk_period_ns;
   localparam int unsigned ocp_retry_us        = 1350;
   localparam int unsigned ocp_retry_cycles    = ocp_retry_us * 1000 / clk_period_ns;

   // counter widths
   localparam int unsigned period_cnt_w   = 11;
   localparam int unsigned blank_cnt_w    = 9;
   localparam int unsigned dead_cnt_w     = 6;
   localparam int unsigned deglitch_cnt_w = 9;
   localparam int unsigned wake_cnt_w     = 17;
   localparam int unsigned retry_cnt_w    = 18;

   // counter end and load values
   localparam logic [period_cnt_w-1:0]   period_last   = period_cnt_w'(chop_period_cycles - 1);
   localparam logic [blank_cnt_w-1:0]    blank_load    = blank_cnt_w'(blank_cycles);
   localparam logic [dead_cnt_w-1:0]     dead_load     = dead_cnt_w'(dead_cycles);
   localparam logic [deglitch_cnt_w-1:0] deglitch_last = deglitch_cnt_w'(ocp_deglitch_cycles - 1);

   // one half-bridge: both switches off is high impedance
   typedef struct packed {
      logic high;
      logic low;
   } half_gate_type;

   typedef struct packed {
      half_gate_type one;
      half_gate_type two;
   } bridge_gate_type;

   typedef struct packed {
      logic one;
      logic two;
   } bridge_input_type;

   // analog current limit flags, per output, per switch
   typedef struct packed {
      logic [1:0] high;
      logic [1:0] low;
   } overcurrent_flags_type;

   // everything sampled from pins, index 0 is bridge a
   typedef struct packed {
      bridge_input_type [1:0]      bridge_in;
      logic [1:0]                  trip;
      overcurrent_flags_type [1:0] oc;
      logic                        sleep_n;
      logic                        thermal;
      logic                        supply_low;
   } pin_sample_type;

   localparam half_gate_type   half_off      = 2'h0;
   localparam half_gate_type   half_high     = 2'h2;
   localparam half_gate_type   half_low      = 2'h1;
   localparam bridge_gate_type gates_off     = {half_off, half_off};
   localparam bridge_gate_type gates_brake   = {half_low, half_low};
   localparam bridge_gate_type gates_forward = {half_high, half_low};
   localparam bridge_gate_type gates_reverse = {half_low, half_high};

   typedef struct packed {
      half_gate_type           gate;
      logic [dead_cnt_w-1:0]   dead_cnt;
   } guard_state_type;

   localparam guard_state_type guard_reset = '{gate: half_off, dead_cnt: '0};

   typedef struct packed {
      logic [period_cnt_w-1:0]        period_cnt;
      logic                           period_start;
      logic [wake_cnt_w-1:0]          wake_cnt;
      logic                           awake;
      logic [1:0][blank_cnt_w-1:0]    blank_cnt;
      logic [1:0]                     driving;
      logic [1:0]                     chopped;
      logic [1:0][deglitch_cnt_w-1:0] deglitch_cnt;
      logic [1:0][retry_cnt_w-1:0]    retry_cnt;
      logic [1:0]                     shutdown;
      logic                           fault;
      logic                           fault_n;
   } ctrl_state_type;

   localparam ctrl_state_type ctrl_reset = '{fault_n: 1'b1, default: '0};
endpackage : hbridge_pkg
`default_nettype wire

// ---- input_sync.sv ----
// two flip-flop synchroniser for pin-level inputs
`default_nettype none
module input_sync
   import hbridge_pkg::*;
#(
   parameter int unsigned width = 1
) (
   input  wire logic [width-1:0] async_in,
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   output logic      [width-1:0] sync_out
);
   typedef struct packed {
      logic [width-1:0] first;
      logic [width-1:0] second;
   } sync_state_type;

   sync_state_type st;
   sync_state_type next_st;

   // first stage feeds only the second
   always_comb begin
      next_st.first  = async_in;
      next_st.second = st.first;
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.second;
endmodule : input_sync
`default_nettype wire

// ---- half_gate_guard.sv ----
// one half-bridge gate driver with break-before-make dead time
`default_nettype none
module half_gate_guard
   import hbridge_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          resetn,
   input  wire logic          enable,
   input  wire half_gate_type want,
   output half_gate_type      gate
);
   guard_state_type st;
   guard_state_type next_st;
   half_gate_type   target;

   // turn-off is immediate, turn-on waits out the dead time
   always_comb begin
      next_st = st;
      target  = enable ? want : half_off;
      if (st.dead_cnt != '0) begin
         next_st.dead_cnt = st.dead_cnt - 1'b1;
      end
      if (st.gate != target) begin
         if (st.gate != half_off) begin
            next_st.gate     = half_off;
            next_st.dead_cnt = dead_load;
         end else if (st.dead_cnt == '0) begin
            next_st.gate = target;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st <= guard_reset;
      end else begin
         st <= next_st;
      end
   end

   assign gate = st.gate;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_dead_gap_turnon: assert property ($changed(gate) && gate != half_off |->
      $past(gate) == half_off && $past(st.dead_cnt) == '0)
      else $error("switch turned on inside dead time");

   a_dead_gap_hold: assert property ($fell(|gate) |-> st.dead_cnt == dead_load)
      else $error("dead time not loaded on turn-off");
endmodule : half_gate_guard
`default_nettype wire

// ---- motor_controller_model.sv ----
// far-side controller model driving pwm on the bridge b command pins
`default_nettype none
module motor_controller_model
   import hbridge_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic slow_decay,
   output logic      in_one,
   output logic      in_two
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] pwm_cnt = 8'h00;
   logic       pwm;

   // 200 cycle pwm period, moved just after the edge like any real controller
   always @(posedge sys_clk) begin
      #1;
      pwm_cnt = (pwm_cnt == 8'hc7) ? 8'h00 : pwm_cnt + 8'h01;
   end

   // forward only; slow decay holds one pin high so the winding is shorted between pulses
   assign pwm    = (pwm_cnt < 8'h64);
   assign in_one = slow_decay ? 1'b1 : pwm;
   assign in_two = slow_decay ? pwm : 1'b0;
endmodule : motor_controller_model
`default_nettype wire

// ---- dual_hbridge_chopper_control_tb.sv ----
// self-checking bench for the dual bridge controller
`default_nettype none
module dual_hbridge_chopper_control_tb
   import hbridge_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned wake_sim  = 20;
   localparam int unsigned retry_sim = 30;

   logic                  sys_clk            = 1'b0;
   logic                  resetn             = 1'b0;
   logic                  a_one              = 1'b0;
   logic                  a_two              = 1'b0;
   logic                  sleep_request_n    = 1'b1;
   logic                  trip_a             = 1'b0;
   logic                  thermal_cutoff     = 1'b0;
   logic                  supply_low_lockout = 1'b0;
   logic                  slow_decay         = 1'b1;
   overcurrent_flags_type oc_a               = '0;
   logic                  b_one;
   logic                  b_two;
   half_gate_type         a_out_one;
   half_gate_type         a_out_two;
   half_gate_type         b_out_one;
   half_gate_type         b_out_two;
   logic                  fault_n_out;
   logic                  fault_oe;
   logic                  fault_pin;
   logic [3:0]            gates_a;
   int                    errors      = 0;
   int                    checks_done = 0;

   // 100 MHz clock; open-drain fault pin with pull-up
   always #5 sys_clk = ~sys_clk;
   assign fault_pin = fault_oe ? 1'b0 : 1'b1;
   assign gates_a   = {a_out_one, a_out_two};

   motor_controller_model motor_controller_model_i (
      .sys_clk    (sys_clk),
      .slow_decay (slow_decay),
      .in_one     (b_one),
      .in_two     (b_two)
   );

   // short wake and retry counts keep the run brief
   dual_hbridge_chopper_control #(
      .wake_cycles_p  (wake_sim),
      .retry_cycles_p (retry_sim)
   ) dual_hbridge_chopper_control_i (
      .sys_clk                     (sys_clk),
      .resetn                      (resetn),
      .bridge_a_input_one          (a_one),
      .bridge_a_input_two          (a_two),
      .bridge_b_input_one          (b_one),
      .bridge_b_input_two          (b_two),
      .sleep_request_n             (sleep_request_n),
      .bridge_a_current_sense_trip (trip_a),
      .bridge_b_current_sense_trip (1'b0),
      .bridge_a_overcurrent_guard  (oc_a),
      .bridge_b_overcurrent_guard  (4'h0),
      .thermal_cutoff              (thermal_cutoff),
      .supply_low_lockout          (supply_low_lockout),
      .bridge_a_output_one         (a_out_one),
      .bridge_a_output_two         (a_out_two),
      .bridge_b_output_one         (b_out_one),
      .bridge_b_output_two         (b_out_two),
      .fault_indicator_n_out       (fault_n_out),
      .fault_indicator_n_oe        (fault_oe)
   );

   task automatic print_verdict();
      $display("checks done %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // inputs always move 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step

   // bounded wait on bridge a gates (sel 0) or fault pin level (sel 1)
   task automatic wait_for(input int sel, input logic [3:0] exp, input int bound, output int n);
      n = 0;
      while (((sel == 0) ? gates_a : {3'h0, fault_pin}) !== exp && n < bound) begin
         step(1);
         n++;
      end
      if (n >= bound) begin
         errors++;
         $display("unexpected at %0t: wait ran out", $time);
         print_verdict();
      end
   endtask : wait_for

   task automatic decode_walk();
      logic [1:0] codes [4];
      logic [3:0] exp   [4];
      codes = '{2'h2, 2'h1, 2'h3, 2'h0};
      exp   = '{gates_forward, gates_reverse, gates_brake, gates_off};
      foreach (codes[i]) begin
         {a_one, a_two} = codes[i];
         if (i == 1) begin
            step(20);
            check(gates_a, gates_off, "dead time gap");
         end
         step(60);
         check(gates_a, exp[i], "decode");
         check(b_out_two, half_low, "bridge b slow decay");
      end
   endtask : decode_walk

   task automatic chop_test();
      int n;
      int m;
      trip_a         = 1'b1;
      {a_one, a_two} = 2'h2;
      step(300);
      check(gates_a, gates_forward, "blanked trip");
      wait_for(0, gates_brake, 2600, n);
      check(4'(n >= 73), 4'h1, "minimum on time");
      wait_for(0, gates_forward, 2100, n);
      wait_for(0, gates_brake, 600, n);
      // brake to brake spacing is one internal period
      wait_for(0, gates_forward, 2100, n);
      wait_for(0, gates_brake, 600, m);
      check(4'(n + m == chop_period_cycles), 4'h1, "chop period");
      trip_a = 1'b0;
      wait_for(0, gates_forward, 2100, n);
      check(gates_a, gates_forward, "drive back at period");
   endtask : chop_test

   task automatic oc_test();
      int n;
      oc_a = 4'h1;
      wait_for(1, 4'h0, 500, n);
      check(4'(n >= 400), 4'h1, "deglitch");
      check(gates_a, gates_off, "bridge off");
      check(b_out_two, half_low, "other bridge runs");
      oc_a = 4'h8;
      wait_for(1, 4'h1, retry_sim + 10, n);
      wait_for(1, 4'h0, 500, n);
      check(4'(n >= 390), 4'h1, "retry repeats");
      oc_a = 4'h0;
      wait_for(1, 4'h1, retry_sim + 10, n);
      wait_for(0, gates_forward, 60, n);
   endtask : oc_test

   task automatic thermal_uv_test();
      int n;
      thermal_cutoff = 1'b1;
      wait_for(1, 4'h0, 8, n);
      check(gates_a, gates_off, "thermal off");
      check({b_out_one, b_out_two}, gates_off, "thermal off b");
      thermal_cutoff = 1'b0;
      wait_for(1, 4'h1, 8, n);
      wait_for(0, gates_forward, 60, n);
      supply_low_lockout = 1'b1;
      wait_for(1, 4'h0, 8, n);
      step(1);  // gates follow one edge after the fault pin
      check(gates_a, gates_off, "lockout off");
      supply_low_lockout = 1'b0;
      step(10);
      check(gates_a, gates_off, "lockout wake");
      wait_for(0, gates_forward, wake_sim + 60, n);
      check(fault_pin, 1'b1, "fault released");
   endtask : thermal_uv_test

   task automatic sleep_test();
      int n;
      sleep_request_n = 1'b0;
      step(6);
      check(gates_a, gates_off, "sleep off");
      check(fault_pin, 1'b1, "sleep fault");
      {a_one, a_two} = 2'h1;
      step(20);
      check(gates_a, gates_off, "pins ignored");
      sleep_request_n = 1'b1;
      step(wake_sim / 2);
      check(gates_a, gates_off, "wake hold");
      wait_for(0, gates_reverse, wake_sim + 60, n);
      check(4'(n + wake_sim / 2 >= wake_sim), 4'h1, "wake interval");
   endtask : sleep_test

   // main sequence
   initial begin
      step(20);
      resetn = 1'b1;
      step(wake_sim + 10);
      decode_walk();
      chop_test();
      oc_test();
      thermal_uv_test();
      sleep_test();
      print_verdict();
   end
endmodule : dual_hbridge_chopper_control_tb
`default_nettype wire
